// ===== design/cps_defines.vh
`ifndef CPS_DEFINES_VH
`define CPS_DEFINES_VH

// Register byte addresses
`define CPS_ADDR_CMD        8'h00
`define CPS_ADDR_CTRL       8'h04
`define CPS_ADDR_FIFO       8'h08
`define CPS_ADDR_FIFOLVL    8'h0C
`define CPS_ADDR_WAKECTL    8'h10
`define CPS_ADDR_WAKERLD    8'h14
`define CPS_ADDR_ILIM       8'h18
`define CPS_ADDR_QLIM       8'h1C
`define CPS_ADDR_SAMPLE     8'h20
`define CPS_ADDR_STATUS     8'h24

// Command register fields
`define CPS_CMD_STBY_BIT    7
`define CPS_CMD_CODE_W      5

// Command codes
`define CPS_CODE_IDLE       5'h00
`define CPS_CODE_DETECT     5'h01
`define CPS_CODE_TAGQUERY   5'h04
`define CPS_CODE_RECEIVE    5'h05
`define CPS_CODE_TRANSMIT   5'h06
`define CPS_CODE_TRANSCV    5'h07
`define CPS_CODE_NVMBYTE    5'h08
`define CPS_CODE_NVMPAGE    5'h09
`define CPS_CODE_NVMREAD    5'h0A
`define CPS_CODE_NVMREGS    5'h0C
`define CPS_CODE_PROTO      5'h0D
`define CPS_CODE_RANDOM     5'h1C
`define CPS_CODE_SOFTRST    5'h1F

// Control and wake timer fields
`define CPS_CTRL_RFOFF_BIT  0
`define CPS_WAKE_RUN_BIT    0
`define CPS_WAKE_AUTO_BIT   1
`define CPS_WAKE_RLD_BIT    2

// Limits reset values
`define CPS_ILIM_RESET      16'hFF00
`define CPS_QLIM_RESET      16'hFF00

// Timing and NVM page size
`define CPS_CLK_MHZ         50
`define CPS_PDHOLD_NS       10000
`define CPS_STBYWAKE_NS     15000
`define CPS_STARTUP_NS      2500000
`define CPS_NVM_PAGE_BYTES  64

`endif

// ===== design/cps_fifo.v
`timescale 1ns/1ps
`default_nettype none

module cps_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 512,
  parameter AW    = 9
) (
  input  wire             clk_sys,
  input  wire             clear,
  input  wire             wrEn,
  input  wire [WIDTH-1:0] wrData,
  input  wire             rdEn,
  output reg  [WIDTH-1:0] rdData,
  output wire             full,
  output wire             empty,
  output wire [AW:0]      level
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wrPtr_q;
  reg [AW-1:0]    rdPtr_q;
  reg [AW:0]      count_q;

  wire doWr = wrEn && !full;
  wire doRd = rdEn && !empty;

  assign full  = (count_q == DEPTH[AW:0]);
  assign empty = (count_q == {(AW+1){1'b0}});
  assign level = count_q;

  always @(posedge clk_sys) begin
    if (doWr) begin
      mem[wrPtr_q] <= wrData;
    end
  end

  always @(posedge clk_sys) begin
    if (clear) begin
      wrPtr_q <= {AW{1'b0}};
      rdPtr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
      rdData  <= {WIDTH{1'b0}};
    end else begin
      if (doWr) begin
        wrPtr_q <= (wrPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_q + 1'b1;
      end
      if (doRd) begin
        rdData  <= mem[rdPtr_q];
        rdPtr_q <= (rdPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_q + 1'b1;
      end
      count_q <= count_q + {{AW{1'b0}}, doWr} - {{AW{1'b0}}, doRd};
    end
  end

endmodule // cps_fifo

`default_nettype wire

// ===== design/cps_sequencer.v
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "cps_defines.vh"

//----------
// Command and power sequencer
//----------
module cps_sequencer #(
  parameter PDHOLD_CYC  = (`CPS_PDHOLD_NS * `CPS_CLK_MHZ + 999) / 1000,
  parameter STARTUP_CYC = (`CPS_STARTUP_NS * `CPS_CLK_MHZ + 999) / 1000,
  parameter WAKE_CYC    = (`CPS_STBYWAKE_NS * `CPS_CLK_MHZ + 999) / 1000,
  parameter FIFO_DEPTH  = 512,
  parameter FIFO_AW     = 9
) (
  input  wire        clk_sys,
  input  wire        rst_n,
  input  wire        power_down_pin,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        txDone,
  input  wire        rxDone,
  input  wire        tagDone,
  input  wire        nvmDone,
  input  wire [7:0]  rngByte,
  input  wire [7:0]  iSample,
  input  wire [7:0]  qSample,
  input  wire        sampleValid,
  output reg         txEnable,
  output reg         rxEnable,
  output reg         txByteValid,
  output reg  [7:0]  txByte,
  output reg         nvmPageStart,
  output reg  [7:0]  nvmPageAddr,
  output reg         nvmByteValid,
  output reg  [7:0]  nvmByte,
  output reg         card_detect_irq,
  output reg         standbyActive,
  output reg         outEnable
);

  //----------
  // Pin synchroniser and power-down filter
  //----------
  reg        pdSync1_q;
  reg        pdSync2_q;
  reg [31:0] pdCnt_q;
  reg        pdReset_q;
  reg [31:0] bootCnt_q;
  reg        ready_q;

  always @(posedge clk_sys) begin
    pdSync1_q <= power_down_pin;
    pdSync2_q <= pdSync1_q;
  end

  wire hardReset = pdReset_q || !rst_n;

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      pdCnt_q   <= 32'h0000_0000;
      pdReset_q <= 1'b0;
    end else if (!pdSync2_q) begin
      pdCnt_q   <= 32'h0000_0000;
      pdReset_q <= 1'b0;
    end else if (pdCnt_q >= PDHOLD_CYC - 1) begin
      pdReset_q <= 1'b1;
    end else begin
      pdCnt_q   <= pdCnt_q + 32'h0000_0001;
    end
  end

  //----------
  // Registers
  //----------
  reg [4:0]  cmd_q;
  reg        stbyReq_q;
  reg        rfOff_q;
  reg [2:0]  wakeCtl_q;
  reg [15:0] wakeReload_q;
  reg [15:0] wakeCnt_q;
  reg [15:0] iLim_q;
  reg [15:0] qLim_q;
  reg [7:0]  iRes_q;
  reg [7:0]  qRes_q;
  reg        softRst_q;
  reg [31:0] wakeDly_q;

  wire setup   = psel && !penable;
  wire access  = psel && penable;
  wire mapped  = (paddr[1:0] == 2'b00) && (paddr <= `CPS_ADDR_STATUS);
  wire wrAcc   = access && pwrite && mapped;
  // Reads of 00h stall until start-up finished
  assign pready  = !(access && !pwrite && !ready_q && paddr == `CPS_ADDR_CMD);
  assign pslverr = access && !mapped;
  wire cmdWr   = wrAcc && pready && paddr == `CPS_ADDR_CMD;

  //----------
  // FIFO
  //----------
  reg        fifoWr;
  reg [7:0]  fifoWrData;
  reg        fifoRd;
  wire [7:0] fifoRdData;
  wire       fifoFull;
  wire       fifoEmpty;
  wire [FIFO_AW:0] fifoLevel;
  wire       fifoClear = hardReset || softRst_q;

  cps_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) uFifo (
    .clk_sys (clk_sys),
    .clear   (fifoClear),
    .wrEn    (fifoWr),
    .wrData  (fifoWrData),
    .rdEn    (fifoRd),
    .rdData  (fifoRdData),
    .full    (fifoFull),
    .empty   (fifoEmpty),
    .level   (fifoLevel)
  );

  //----------
  // Command state machine
  //----------
  localparam [6:0] S_IDLE  = 7'b0000001;
  localparam [6:0] S_XMIT  = 7'b0000010;
  localparam [6:0] S_RECV  = 7'b0000100;
  localparam [6:0] S_TAG   = 7'b0001000;
  localparam [6:0] S_DWAIT = 7'b0010000;
  localparam [6:0] S_PAGE  = 7'b0100000;
  localparam [6:0] S_FILL  = 7'b1000000;

  reg [6:0] state_q;
  reg       txAfterRx_q;
  reg [6:0] pageCnt_q;
  reg       pageAddrTaken_q;
  reg       rdPend_q;

  wire apbFifoWr = wrAcc && paddr == `CPS_ADDR_FIFO;
  wire apbFifoRd = access && !pwrite && paddr == `CPS_ADDR_FIFO;
  wire wakeRun   = wakeCtl_q[`CPS_WAKE_RUN_BIT];
  wire wakeExp   = wakeRun && (wakeCnt_q == 16'h0000);
  wire outLimit  = (iSample < iLim_q[7:0]) || (iSample > iLim_q[15:8]) ||
                   (qSample < qLim_q[7:0]) || (qSample > qLim_q[15:8]);

  always @* begin
    fifoWr     = apbFifoWr;
    fifoWrData = pwdata[7:0];
    fifoRd     = apbFifoRd;
    if (state_q == S_FILL && !fifoFull) begin
      fifoWr     = 1'b1;
      fifoWrData = rngByte;
    end
    if ((state_q == S_XMIT || state_q == S_PAGE) && !fifoEmpty && !rdPend_q) begin
      fifoRd = 1'b1;
    end
  end

  always @(posedge clk_sys) begin
    if (hardReset || softRst_q) begin
      state_q         <= S_IDLE;
      cmd_q           <= `CPS_CODE_IDLE;
      stbyReq_q       <= 1'b0;
      rfOff_q         <= 1'b0;
      wakeCtl_q       <= 3'b000;
      wakeReload_q    <= 16'h0000;
      wakeCnt_q       <= 16'h0000;
      iLim_q          <= `CPS_ILIM_RESET;
      qLim_q          <= `CPS_QLIM_RESET;
      iRes_q          <= 8'h00;
      qRes_q          <= 8'h00;
      softRst_q       <= 1'b0;
      txAfterRx_q     <= 1'b0;
      pageCnt_q       <= 7'h00;
      pageAddrTaken_q <= 1'b0;
      rdPend_q        <= 1'b0;
      card_detect_irq <= 1'b0;
      txByteValid     <= 1'b0;
      txByte          <= 8'h00;
      nvmPageStart    <= 1'b0;
      nvmPageAddr     <= 8'h00;
      nvmByteValid    <= 1'b0;
      nvmByte         <= 8'h00;
      wakeDly_q       <= 32'h0000_0000;
    end else begin
      txByteValid  <= 1'b0;
      nvmPageStart <= 1'b0;
      nvmByteValid <= 1'b0;
      rdPend_q     <= fifoRd && (state_q == S_XMIT || state_q == S_PAGE);
      if (sampleValid && state_q == S_DWAIT) begin
        iRes_q <= iSample;
        qRes_q <= qSample;
      end
      // Wake timer
      if (wakeRun && !standbyActive) begin
        wakeCnt_q <= wakeCnt_q;
      end else if (wakeExp) begin
        wakeCnt_q <= wakeReload_q;
        if (!wakeCtl_q[`CPS_WAKE_RLD_BIT]) begin
          wakeCtl_q[`CPS_WAKE_RUN_BIT] <= 1'b0;
        end
        if (wakeCtl_q[`CPS_WAKE_AUTO_BIT]) begin
          stbyReq_q <= 1'b0;
        end
      end else if (wakeRun) begin
        wakeCnt_q <= wakeCnt_q - 16'h0001;
      end
      if (standbyActive && !stbyReq_q) begin
        wakeDly_q <= wakeDly_q + 32'h0000_0001;
      end else begin
        wakeDly_q <= 32'h0000_0000;
      end
      case (state_q)
        S_XMIT: begin
          if (rdPend_q) begin
            txByteValid <= 1'b1;
            txByte      <= fifoRdData;
          end else if (fifoEmpty && txDone && !fifoRd) begin
            if (txAfterRx_q) begin
              state_q <= S_RECV;
            end else begin
              state_q <= S_IDLE;
              cmd_q   <= `CPS_CODE_IDLE;
            end
          end
        end
        S_RECV: begin
          if (rxDone) begin
            state_q <= S_IDLE;
            cmd_q   <= `CPS_CODE_IDLE;
          end
        end
        S_TAG: begin
          if (tagDone) begin
            state_q <= S_IDLE;
            cmd_q   <= `CPS_CODE_IDLE;
          end
        end
        S_DWAIT: begin
          if (sampleValid) begin
            state_q <= S_IDLE;
            cmd_q   <= `CPS_CODE_IDLE;
            if (outLimit) begin
              card_detect_irq <= 1'b1;
            end else if (!wakeCtl_q[`CPS_WAKE_AUTO_BIT]) begin
              stbyReq_q <= 1'b0;
            end
          end
        end
        S_PAGE: begin
          if (rdPend_q) begin
            if (!pageAddrTaken_q) begin
              nvmPageAddr     <= fifoRdData;
              pageAddrTaken_q <= 1'b1;
            end else begin
              nvmByteValid <= 1'b1;
              nvmByte      <= fifoRdData;
              pageCnt_q    <= pageCnt_q + 7'h01;
            end
          end else if (!fifoRd && pageAddrTaken_q &&
                       (fifoEmpty || pageCnt_q == `CPS_NVM_PAGE_BYTES)) begin
            nvmPageStart <= 1'b1;
            state_q      <= S_IDLE;
            cmd_q        <= `CPS_CODE_IDLE;
          end
        end
        S_FILL: begin
          if (fifoFull) begin
            state_q <= S_IDLE;
            cmd_q   <= `CPS_CODE_IDLE;
          end
        end
        S_IDLE: begin
          // Card detect: standby phase, then detection once awake
          if (cmd_q == `CPS_CODE_DETECT && !standbyActive && !stbyReq_q) begin
            state_q <= S_DWAIT;
          end else if (cmd_q == `CPS_CODE_NVMPAGE && fifoLevel != {(FIFO_AW+1){1'b0}}) begin
            state_q <= S_PAGE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
      if (card_detect_irq && wrAcc && paddr == `CPS_ADDR_STATUS && pwdata[0] && !(state_q == S_DWAIT &&
          sampleValid && outLimit)) begin
        card_detect_irq <= 1'b0;
      end
      if (wrAcc && paddr == `CPS_ADDR_CTRL) begin
        rfOff_q <= pwdata[`CPS_CTRL_RFOFF_BIT];
      end
      if (wrAcc && paddr == `CPS_ADDR_WAKECTL) begin
        wakeCtl_q <= pwdata[2:0];
        wakeCnt_q <= wakeReload_q;
      end
      if (wrAcc && paddr == `CPS_ADDR_WAKERLD) begin
        wakeReload_q <= pwdata[15:0];
      end
      if (wrAcc && paddr == `CPS_ADDR_ILIM) begin
        iLim_q <= pwdata[15:0];
      end
      if (wrAcc && paddr == `CPS_ADDR_QLIM) begin
        qLim_q <= pwdata[15:0];
      end
      if (cmdWr) begin
        stbyReq_q       <= pwdata[`CPS_CMD_STBY_BIT];
        cmd_q           <= pwdata[4:0];
        txAfterRx_q     <= 1'b0;
        pageCnt_q       <= 7'h00;
        pageAddrTaken_q <= 1'b0;
        case (pwdata[4:0])
          `CPS_CODE_IDLE:     state_q <= S_IDLE;
          `CPS_CODE_DETECT:   state_q <= S_IDLE;
          `CPS_CODE_TAGQUERY: state_q <= S_TAG;
          `CPS_CODE_RECEIVE:  state_q <= S_RECV;
          `CPS_CODE_TRANSMIT: state_q <= S_XMIT;
          `CPS_CODE_TRANSCV: begin
            state_q     <= S_XMIT;
            txAfterRx_q <= 1'b1;
          end
          `CPS_CODE_NVMPAGE:  state_q <= S_IDLE;
          `CPS_CODE_RANDOM:   state_q <= S_FILL;
          `CPS_CODE_SOFTRST: begin
            state_q   <= S_IDLE;
            softRst_q <= 1'b1;
          end
          default:            state_q <= S_IDLE;
        endcase
      end
    end
  end

  //----------
  // Power states and start-up
  //----------
  always @(posedge clk_sys) begin
    if (hardReset) begin
      bootCnt_q     <= 32'h0000_0000;
      ready_q       <= 1'b0;
      standbyActive <= 1'b0;
      outEnable     <= 1'b0;
    end else begin
      outEnable <= 1'b1;
      if (!ready_q) begin
        if (bootCnt_q >= STARTUP_CYC - 1) begin
          ready_q <= 1'b1;
        end else begin
          bootCnt_q <= bootCnt_q + 32'h0000_0001;
        end
      end
      if (stbyReq_q) begin
        standbyActive <= 1'b1;
      end else if (standbyActive && wakeDly_q >= WAKE_CYC - 1) begin
        standbyActive <= 1'b0;
      end
    end
  end

  //----------
  // RF enables
  //----------
  always @(posedge clk_sys) begin
    if (hardReset) begin
      txEnable <= 1'b0;
      rxEnable <= 1'b0;
    end else begin
      txEnable <= !rfOff_q && !standbyActive && (state_q == S_XMIT || state_q == S_TAG);
      rxEnable <= !rfOff_q && !standbyActive && (state_q == S_RECV || state_q == S_TAG || state_q == S_DWAIT);
    end
  end

  //----------
  // Read mux
  //----------
  always @(posedge clk_sys) begin
    if (hardReset) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      case (paddr)
        `CPS_ADDR_CMD:     prdata <= {24'h000000, stbyReq_q, 2'b00, cmd_q};
        `CPS_ADDR_CTRL:    prdata <= {31'h00000000, rfOff_q};
        `CPS_ADDR_FIFOLVL: prdata <= {{(31-FIFO_AW){1'b0}}, fifoLevel};
        `CPS_ADDR_WAKECTL: prdata <= {29'h00000000, wakeCtl_q};
        `CPS_ADDR_WAKERLD: prdata <= {16'h0000, wakeCnt_q};
        `CPS_ADDR_ILIM:    prdata <= {16'h0000, iLim_q};
        `CPS_ADDR_QLIM:    prdata <= {16'h0000, qLim_q};
        `CPS_ADDR_SAMPLE:  prdata <= {16'h0000, qRes_q, iRes_q};
        `CPS_ADDR_STATUS:  prdata <= {28'h0000000, ready_q, standbyActive, fifoFull, card_detect_irq};
        // Byte popped by the previous read
        `CPS_ADDR_FIFO:    prdata <= {24'h000000, fifoRdData};
        default:           prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule // cps_sequencer

`default_nettype wire

// ===== test/cps_seq_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module cps_seq_asserts #(
  parameter STARTUP_CYC = 20
) (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        power_down_pin,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        sampleValid,
  input wire logic        txEnable,
  input wire logic        rxEnable,
  input wire logic        card_detect_irq,
  input wire logic        standbyActive,
  input wire logic        outEnable
);
  //----------
  // Helper state
  //----------
  logic        wrCmd;
  logic        rfOff_q;
  logic [31:0] upCnt_q;
  assign wrCmd = psel && penable && pready && pwrite && (paddr == 8'h00);
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      rfOff_q <= 1'b0;
      upCnt_q <= 32'h0;
    end else begin
      if (psel && penable && pready && pwrite && (paddr == 8'h04)) begin
        rfOff_q <= pwdata[0];
      end
      if (upCnt_q < STARTUP_CYC) begin
        upCnt_q <= upCnt_q + 32'h1;
      end
    end
  end
  //----------
  // Properties
  //----------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_pd_long;
    power_down_pin [*8];
  endsequence
  sequence s_wake;
    standbyActive [*4] ##[1:3] !standbyActive;
  endsequence
  a_pd_tristate: assert property (s_pd_long |=> !outEnable)
    else $error("outputs on in power down");
  a_stby_enter: assert property (wrCmd && pwdata[7] |-> ##2 standbyActive)
    else $error("standby not entered");
  a_stby_exit: assert property (wrCmd && !pwdata[7] && standbyActive |=> s_wake)
    else $error("late standby exit");
  a_stby_hold: assert property (standbyActive && $past(standbyActive) |-> $stable(txEnable) && $stable(rxEnable))
    else $error("outputs moved in standby");
  a_rf_off: assert property (rfOff_q && $past(rfOff_q) |-> !txEnable && !rxEnable)
    else $error("frontend on while off");
  a_abort_cmd: assert property (wrCmd && pwdata[4:0] == 5'h00 |-> ##2 (!txEnable && !rxEnable))
    else $error("idle did not abort");
  a_ready_stall: assert property (psel && penable && !pwrite && paddr == 8'h00 && upCnt_q < STARTUP_CYC - 4 |-> !pready)
    else $error("early command read answer");
  a_irq_cause: assert property ($rose(card_detect_irq) |-> $past(sampleValid) || $past(sampleValid, 2))
    else $error("irq without sample");
endmodule // cps_seq_asserts
`default_nettype wire

// ===== test/cps_datapath_model.sv
`timescale 1ns/1ps
`default_nettype none
module cps_datapath_model (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       txEnable,
  input  wire logic       rxEnable,
  input  wire logic [3:0] dly,
  input  wire logic       tagKick,
  input  wire logic       sampleKick,
  input  wire logic [7:0] iVal,
  output logic            txDone,
  output logic            rxDone,
  output logic            tagDone,
  output logic            nvmDone,
  output logic [7:0]      rngByte,
  output logic [7:0]      iSample,
  output logic [7:0]      qSample,
  output logic            sampleValid
);
  logic [3:0] txCnt_q;
  logic [3:0] rxCnt_q;
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      txCnt_q     <= 4'h0;
      rxCnt_q     <= 4'h0;
      txDone      <= 1'b0;
      rxDone      <= 1'b0;
      tagDone     <= 1'b0;
      nvmDone     <= 1'b0;
      rngByte     <= 8'h5C;
      iSample     <= 8'h00;
      qSample     <= 8'h00;
      sampleValid <= 1'b0;
    end else begin
      txCnt_q     <= txEnable ? txCnt_q + {3'h0, txCnt_q != dly} : 4'h0;
      rxCnt_q     <= rxEnable ? rxCnt_q + {3'h0, rxCnt_q != dly} : 4'h0;
      txDone      <= txEnable && (txCnt_q == dly);
      rxDone      <= rxEnable && (rxCnt_q == dly);
      tagDone     <= tagKick;
      nvmDone     <= 1'b0;
      rngByte     <= rngByte + 8'h3B;
      // Samples toggle outside the valid cycle
      iSample     <= sampleKick ? iVal : ~iSample;
      qSample     <= sampleKick ? 8'h40 : ~qSample;
      sampleValid <= sampleKick;
    end
  end
endmodule // cps_datapath_model
`default_nettype wire

// ===== test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic             clk_sys = 1'b0;
  logic             rst_n = 1'b0;
  logic             power_down_pin = 1'b0;
  logic             psel = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite = 1'b0;
  logic [7:0]       paddr = 8'h00;
  logic [31:0]      pwdata = 32'h0;
  logic [3:0]       dly = 4'h2;
  logic             tagKick = 1'b0;
  logic             sampleKick = 1'b0;
  logic [7:0]       iVal = 8'h00;
  logic [7:0]       smp [3] = '{8'h90, 8'h10, 8'h80};
  logic [31:0]      rd;
  logic             err;
  wire logic [31:0] prdata;
  wire logic [7:0]  rngByte, iSample, qSample, nvmPageAddr, txByte, nvmByte;
  wire logic        pready, pslverr, txDone, rxDone, tagDone, nvmDone, sampleValid, txEnable, rxEnable;
  wire logic        txByteValid, nvmPageStart, nvmByteValid, card_detect_irq, standbyActive, outEnable;
  int               miscompares = 0;
  int               samples_checked = 0;
  int               txSeen = 0, rxSeen = 0, nvmSeen = 0, pageSeen = 0;
  int               k, b, p;
  logic [7:0]       txLast = 8'h00, nvmLast = 8'h00;

  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    txSeen <= txSeen + int'(txByteValid);
    rxSeen <= rxSeen + int'(rxEnable);
    nvmSeen <= nvmSeen + int'(nvmByteValid);
    pageSeen <= pageSeen + int'(nvmPageStart);
    if (txByteValid) txLast <= txByte;
    if (nvmByteValid) nvmLast <= nvmByte;
  end

  cps_sequencer #(.PDHOLD_CYC(4), .STARTUP_CYC(20), .WAKE_CYC(5), .FIFO_DEPTH(16), .FIFO_AW(4)) cps_sequencer_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .power_down_pin(power_down_pin), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .txDone(txDone), .rxDone(rxDone), .tagDone(tagDone), .nvmDone(nvmDone), .rngByte(rngByte),
    .iSample(iSample), .qSample(qSample), .sampleValid(sampleValid), .txEnable(txEnable),
    .rxEnable(rxEnable), .txByteValid(txByteValid), .txByte(txByte), .nvmPageStart(nvmPageStart),
    .nvmPageAddr(nvmPageAddr), .nvmByteValid(nvmByteValid), .nvmByte(nvmByte), .card_detect_irq(card_detect_irq),
    .standbyActive(standbyActive), .outEnable(outEnable));
  cps_datapath_model cps_datapath_model_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .txEnable(txEnable), .rxEnable(rxEnable), .dly(dly), .tagKick(tagKick),
    .sampleKick(sampleKick), .iVal(iVal), .txDone(txDone), .rxDone(rxDone), .tagDone(tagDone),
    .nvmDone(nvmDone), .rngByte(rngByte), .iSample(iSample), .qSample(qSample), .sampleValid(sampleValid));

  //----------
  // Bus and check tasks
  //----------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 400);
    if (n >= 400) begin
      miscompares++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    k = n;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic waitCmd(input logic [4:0] e);
    int m;
    m = 0;
    do begin
      apb(8'h00, 1'b0, 32'h0);
      m++;
    end while (rd[4:0] !== e && m < 100);
    chk("cmdCode", {27'h0, e}, {27'h0, rd[4:0]});
  endtask

  //----------
  // Main sequence
  //----------
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    apb(8'h00, 1'b0, 32'h0);
    chk("startStall", 32'h1, 32'(k > 12));
    chk("cmdIdle", 32'h0, rd & 32'h1F);
    $display("test startup done");
    for (int i = 0; i < 3; i++) apb(8'h08, 1'b1, 32'h11 + i);
    b = txSeen;
    apb(8'h00, 1'b1, 32'h06);
    waitCmd(5'h00);
    chk("txBytes", 32'd3, 32'(txSeen - b));
    chk("txLast", 32'h13, {24'h0, txLast});
    apb(8'h08, 1'b1, 32'h21);
    b = rxSeen;
    apb(8'h00, 1'b1, 32'h07);
    waitCmd(5'h00);
    chk("rxAfterTx", 32'h1, 32'(rxSeen > b));
    $display("test transmit done");
    dly <= 4'hF;
    apb(8'h00, 1'b1, 32'h05);
    waitCmd(5'h05);
    chk("rxOn", 32'h1, {31'h0, rxEnable});
    apb(8'h00, 1'b1, 32'h00);
    repeat (2) @(posedge clk_sys);
    chk("rxAbort", 32'h0, {31'h0, rxEnable});
    dly <= 4'h2;
    apb(8'h00, 1'b1, 32'h04);
    waitCmd(5'h04);
    tagKick <= 1'b1;
    @(posedge clk_sys);
    tagKick <= 1'b0;
    waitCmd(5'h00);
    $display("test abort done");
    apb(8'h04, 1'b1, 32'h1);
    apb(8'h04, 1'b0, 32'h0);
    chk("ctrlRead", 32'h1, rd & 32'h1);
    apb(8'h00, 1'b1, 32'h05);
    repeat (3) @(posedge clk_sys);
    chk("rfOffRx", 32'h0, {31'h0, rxEnable});
    apb(8'h00, 1'b1, 32'h00);
    apb(8'h04, 1'b1, 32'h0);
    $display("test rf off done");
    apb(8'h0C, 1'b0, 32'h0);
    chk("levelEmpty", 32'h0, rd);
    apb(8'h08, 1'b1, 32'h5A);
    apb(8'h00, 1'b1, 32'h80);
    repeat (2) @(posedge clk_sys);
    chk("stbyOn", 32'h1, {31'h0, standbyActive});
    apb(8'h0C, 1'b0, 32'h0);
    chk("stbyLevel", 32'h1, rd);
    apb(8'h00, 1'b1, 32'h00);
    k = 0;
    while (standbyActive === 1'b1 && k < 50) begin
      @(posedge clk_sys);
      k++;
    end
    chk("wakeCyc", 32'h1, 32'(k >= 3 && k <= 7));
    apb(8'h08, 1'b0, 32'h0);
    apb(8'h08, 1'b0, 32'h0);
    chk("stbyFifo", 32'h5A, rd & 32'hFF);
    $display("test standby done");
    apb(8'h18, 1'b1, 32'h8020);
    for (int i = 0; i < 3; i++) begin
      apb(8'h24, 1'b1, 32'h1);
      apb(8'h00, 1'b1, 32'h01);
      iVal <= smp[i];
      sampleKick <= 1'b1;
      @(posedge clk_sys);
      sampleKick <= 1'b0;
      repeat (3) @(posedge clk_sys);
      apb(8'h24, 1'b0, 32'h0);
      chk("detectIrq", {31'h0, i < 2}, {31'h0, rd[0]});
    end
    apb(8'h20, 1'b0, 32'h0);
    chk("samples", 32'h4080, rd & 32'hFFFF);
    apb(8'h00, 1'b1, 32'h00);
    apb(8'h14, 1'b1, 32'h8);
    apb(8'h10, 1'b1, 32'h7);
    apb(8'h00, 1'b1, 32'h81);
    repeat (2) @(posedge clk_sys);
    chk("detStby", 32'h1, {31'h0, standbyActive});
    k = 0;
    while (standbyActive === 1'b1 && k < 100) begin
      @(posedge clk_sys);
      k++;
    end
    chk("autoWake", 32'h0, {31'h0, standbyActive});
    apb(8'h10, 1'b1, 32'h0);
    apb(8'h00, 1'b1, 32'h00);
    $display("test detect done");
    apb(8'h00, 1'b1, 32'h1C);
    k = 0;
    do begin
      apb(8'h24, 1'b0, 32'h0);
      k++;
    end while (rd[1] !== 1'b1 && k < 100);
    apb(8'h0C, 1'b0, 32'h0);
    chk("fillLevel", 32'd16, rd);
    apb(8'h00, 1'b1, 32'h1F);
    repeat (3) @(posedge clk_sys);
    apb(8'h0C, 1'b0, 32'h0);
    chk("srstLevel", 32'h0, rd);
    apb(8'h18, 1'b0, 32'h0);
    chk("srstLimit", 32'hFF00, rd);
    $display("test fill done");
    apb(8'h08, 1'b1, 32'h12);
    apb(8'h08, 1'b1, 32'hAA);
    apb(8'h08, 1'b1, 32'hBB);
    b = nvmSeen;
    p = pageSeen;
    apb(8'h00, 1'b1, 32'h09);
    waitCmd(5'h00);
    chk("pageGo", 32'(p + 1), 32'(pageSeen));
    chk("pageAddr", 32'h12, {24'h0, nvmPageAddr});
    chk("pageBytes", 32'd2, 32'(nvmSeen - b));
    chk("pageData", 32'hBB, {24'h0, nvmLast});
    p = pageSeen;
    apb(8'h00, 1'b1, 32'h09);
    repeat (10) @(posedge clk_sys);
    chk("pageWait", 32'(p), 32'(pageSeen));
    apb(8'h08, 1'b1, 32'h34);
    waitCmd(5'h00);
    chk("pageAddr2", 32'h34, {24'h0, nvmPageAddr});
    $display("test page done");
    apb(8'h08, 1'b1, 32'h77);
    power_down_pin <= 1'b1;
    repeat (2) @(posedge clk_sys);
    power_down_pin <= 1'b0;
    repeat (6) @(posedge clk_sys);
    apb(8'h0C, 1'b0, 32'h0);
    chk("glitchKeep", 32'h1, rd);
    power_down_pin <= 1'b1;
    repeat (12) @(posedge clk_sys);
    chk("pdOutEn", 32'h0, {31'h0, outEnable});
    power_down_pin <= 1'b0;
    apb(8'h00, 1'b0, 32'h0);
    chk("pdStall", 32'h1, 32'(k > 8));
    apb(8'h0C, 1'b0, 32'h0);
    chk("pdLevel", 32'h0, rd);
    apb(8'h40, 1'b0, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    $display("test power down done");
    tally_and_finish();
  end
endmodule // tb_top

bind cps_sequencer cps_seq_asserts #(.STARTUP_CYC(STARTUP_CYC)) cps_seq_asserts_i (
  .clk_sys(clk_sys), .rst_n(rst_n), .power_down_pin(power_down_pin), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .sampleValid(sampleValid),
  .txEnable(txEnable), .rxEnable(rxEnable), .card_detect_irq(card_detect_irq),
  .standbyActive(standbyActive), .outEnable(outEnable));
`default_nettype wire
